// ---- rtl/ras_regs.vh ----
// register map, field positions and reset values of the return stack
`ifndef RAS_REGS_VH
`define RAS_REGS_VH

// byte offsets on the register bus
`define RAS_OFS_CONTROL 4'h0
`define RAS_OFS_TOP_LOW 4'h4
`define RAS_OFS_TOP_HIGH 4'h8
`define RAS_OFS_TOP_UPPER 4'hC

// return_stack_control fields
`define RAS_BIT_FULL 7
`define RAS_BIT_UNDERFLOW 6
`define RAS_BIT_RSVD 5
`define RAS_IDX_MSB 4
`define RAS_IDX_LSB 0

// stack geometry
`define RAS_PC_W 21
`define RAS_IDX_W 5
`define RAS_DEPTH 31
`define RAS_IDX_TOP 5'h1F
`define RAS_IDX_LAST_FREE 5'h1E
`define RAS_PC_STEP 21'h000002
`define RAS_RESET_VECTOR 21'h000000

// reset values
`define RAS_IDX_RST 5'h00
`define RAS_FLAG_RST 1'b0
`define RAS_SHADOW_RST 8'h00

// bus answers
`define RAS_RESP_OKAY 2'h0
`define RAS_RESP_SLVERR 2'h2

`endif

// ---- rtl/ras_stack.v ----
// return address stack with top-entry registers and fast shadow stack
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "ras_regs.vh"

// Function
// RULE1: thirty-one entries; push on call, relative call, interrupt
// RULE2: returns load saved address into program counter
// RULE3: calls and returns never touch latch registers
// RULE4: 31x21 storage, 5-bit index, reset to zero
// RULE5: push increments index, then writes entry
// RULE6: pop reads entry, then decrements index
// RULE7: three byte registers read/write selected entry
// RULE8: software reads and writes index 0..31
// RULE9: full flag after 31 unpopped pushes
// RULE10: error reset on: store pc+2, reset, index 0
// RULE11: error reset off: index 31, no overwrite
// RULE12: empty pop gives zero, underflow, index stays
// RULE13: error reset on: flag then device reset
// RULE14: control: full b7, underflow b6, b5 zero, index
// RULE15: flags cleared only by software or power-on
// RULE16: explicit push stores current program counter
// RULE17: explicit pop discards top by decrementing
// RULE18: interrupt vectoring loads hidden one-deep shadow
// RULE19: fast interrupt return restores shadow values
// RULE20: both priorities load shadow, overwriting older
// RULE21: fast call loads shadow for fast return
// RULE22: software masks interrupts while editing top
// RULE23: writing zero clears flag, one leaves it
module ras_stack (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    input wire power_on_reset,
    // configuration
    input wire stack_error_reset_enable,
    // sequencer requests
    input wire call_push,
    input wire irq_ack,
    input wire push_op,
    input wire ret_pop,
    input wire pop_op,
    input wire fast_form,
    input wire [20:0] pc_in,
    input wire [7:0] status_in,
    input wire [7:0] working_register_in,
    input wire [7:0] bank_select_register_in,
    // sequencer answers
    output reg pc_load,
    output reg [20:0] pc_load_value,
    output reg shadow_restore,
    output reg [7:0] status_out,
    output reg [7:0] working_register_out,
    output reg [7:0] bank_select_register_out,
    output reg stack_reset_req,
    output wire stack_full_flag,
    output wire stack_underflow_flag,
    output wire [4:0] stack_depth_index,
    // axi4-lite write address
    input wire [3:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [3:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

////////////////////////////////////////////////////////////////////////////
// state

reg [20:0] stack_mem [1:`RAS_DEPTH];
reg [4:0] idx_q;
reg [4:0] idx_d;
reg full_q;
reg full_d;
reg unf_q;
reg unf_d;
reg [7:0] sh_status_q;
reg [7:0] sh_working_register_q;
reg [7:0] sh_bsr_q;

reg mem_we;
reg [4:0] mem_idx;
reg [20:0] mem_wdata;

reg pc_load_d;
reg [20:0] pc_value_d;
reg reset_req_d;

wire [20:0] top_entry;
wire [4:0] idx_inc;
wire [4:0] idx_dec;
wire do_push;
wire do_pop;
wire seq_busy;

// index zero has no storage behind it and reads as zero
assign top_entry = (idx_q == `RAS_IDX_RST) ? `RAS_RESET_VECTOR :
                   stack_mem[idx_q]; // [RULE4] [RULE7]
assign idx_inc = idx_q + 5'h01;
assign idx_dec = idx_q - 5'h01;
assign do_push = call_push | irq_ack | push_op; // [RULE1] [RULE16]
assign do_pop = ~do_push & (ret_pop | pop_op);
assign seq_busy = do_push | do_pop;

assign stack_full_flag = full_q;
assign stack_underflow_flag = unf_q;
assign stack_depth_index = idx_q;

////////////////////////////////////////////////////////////////////////////
// axi4-lite slave

reg aw_held_q;
reg [3:0] aw_addr_q;
reg w_held_q;
reg [31:0] w_data_q;
reg w_strb0_q;
reg ar_done_q;

wire aw_take;
wire w_take;
wire wr_fire;
wire ar_take;
wire wr_ctrl;
wire wr_low;
wire wr_high;
wire wr_upper;
wire wr_mapped;

assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
assign s_axi_arready = ~s_axi_rvalid;
assign aw_take = s_axi_awvalid & s_axi_awready;
assign w_take = s_axi_wvalid & s_axi_wready;
assign wr_fire = aw_held_q & w_held_q & ~s_axi_bvalid;
assign ar_take = s_axi_arvalid & s_axi_arready;

assign wr_mapped = (aw_addr_q == `RAS_OFS_CONTROL) |
                   (aw_addr_q == `RAS_OFS_TOP_LOW) |
                   (aw_addr_q == `RAS_OFS_TOP_HIGH) |
                   (aw_addr_q == `RAS_OFS_TOP_UPPER);
assign wr_ctrl = wr_fire & w_strb0_q &
                 (aw_addr_q == `RAS_OFS_CONTROL);
assign wr_low = wr_fire & w_strb0_q &
                (aw_addr_q == `RAS_OFS_TOP_LOW);
assign wr_high = wr_fire & w_strb0_q &
                 (aw_addr_q == `RAS_OFS_TOP_HIGH);
assign wr_upper = wr_fire & w_strb0_q &
                  (aw_addr_q == `RAS_OFS_TOP_UPPER);

always @(posedge aclk) begin
    if (!aresetn) begin
        aw_held_q <= 1'b0;
        aw_addr_q <= 4'h0;
        w_held_q <= 1'b0;
        w_data_q <= 32'h00000000;
        w_strb0_q <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `RAS_RESP_OKAY;
    end else begin
        if (aw_take) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end
        if (w_take) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb0_q <= s_axi_wstrb[0];
        end
        if (wr_fire) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? `RAS_RESP_OKAY : `RAS_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// read data sampled at the address handshake
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `RAS_RESP_OKAY;
        ar_done_q <= 1'b0;
    end else begin
        if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RAS_RESP_OKAY;
            ar_done_q <= 1'b1;
            case (s_axi_araddr)
                `RAS_OFS_CONTROL: begin
                    s_axi_rdata <= {24'h000000, full_q, unf_q, 1'b0,
                                    idx_q}; // [RULE14] [RULE8]
                end
                `RAS_OFS_TOP_LOW: begin
                    s_axi_rdata <= {24'h000000, top_entry[7:0]}; // [RULE7]
                end
                `RAS_OFS_TOP_HIGH: begin
                    s_axi_rdata <= {24'h000000, top_entry[15:8]};
                end
                `RAS_OFS_TOP_UPPER: begin
                    s_axi_rdata <= {27'h0000000, top_entry[20:16]};
                end
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `RAS_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            ar_done_q <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// stack operation

always @* begin
    idx_d = idx_q;
    full_d = full_q;
    unf_d = unf_q;
    mem_we = 1'b0;
    mem_idx = idx_inc;
    mem_wdata = pc_in;
    pc_load_d = 1'b0;
    pc_value_d = pc_load_value;
    reset_req_d = 1'b0;
    if (do_push) begin
        if (idx_q == `RAS_IDX_TOP) begin
            // already full: entry 31 kept; index stays, or goes to 0 with error reset on
            full_d = 1'b1; // [RULE11]
            reset_req_d = stack_error_reset_enable; // [RULE13]
            if (stack_error_reset_enable) begin
                idx_d = `RAS_IDX_RST;
            end
        end else if (idx_q == `RAS_IDX_LAST_FREE) begin
            // thirty-first push
            mem_we = 1'b1;
            full_d = 1'b1; // [RULE9]
            if (stack_error_reset_enable) begin
                mem_wdata = pc_in + `RAS_PC_STEP; // [RULE10]
                idx_d = `RAS_IDX_RST; // [RULE10]
                reset_req_d = 1'b1; // [RULE13]
            end else begin
                idx_d = `RAS_IDX_TOP; // [RULE11]
            end
        end else begin
            mem_we = 1'b1; // [RULE5] [RULE16]
            idx_d = idx_inc; // [RULE5]
        end
    end else if (do_pop) begin
        if (idx_q == `RAS_IDX_RST) begin
            unf_d = 1'b1; // [RULE12]
            reset_req_d = stack_error_reset_enable; // [RULE13]
            if (ret_pop) begin
                pc_load_d = 1'b1;
                pc_value_d = `RAS_RESET_VECTOR; // [RULE12]
            end
        end else begin
            idx_d = idx_dec; // [RULE6] [RULE17]
            if (ret_pop) begin
                pc_load_d = 1'b1; // [RULE2]
                pc_value_d = stack_mem[idx_q]; // [RULE6]
            end
        end
    end else begin
        // software access; the sequencer owns the stack when active
        if (wr_ctrl) begin
            idx_d = w_data_q[`RAS_IDX_MSB:`RAS_IDX_LSB]; // [RULE8]
        end
        if ((wr_low || wr_high || wr_upper) &&
            idx_q != `RAS_IDX_RST) begin
            mem_we = 1'b1; // [RULE7]
            mem_idx = idx_q;
            mem_wdata = top_entry;
            if (wr_low) begin
                mem_wdata[7:0] = w_data_q[7:0];
            end
            if (wr_high) begin
                mem_wdata[15:8] = w_data_q[7:0];
            end
            if (wr_upper) begin
                mem_wdata[20:16] = w_data_q[4:0];
            end
        end
    end
    // flag clear by writing zero; a set in the same cycle wins
    if (wr_ctrl && !w_data_q[`RAS_BIT_FULL] &&
        !(do_push && idx_q >= `RAS_IDX_LAST_FREE)) begin
        full_d = 1'b0; // [RULE23] [RULE15]
    end
    if (wr_ctrl && !w_data_q[`RAS_BIT_UNDERFLOW] &&
        !(do_pop && idx_q == `RAS_IDX_RST)) begin
        unf_d = 1'b0; // [RULE23] [RULE15]
    end
end

always @(posedge aclk) begin
    if (mem_we) begin
        stack_mem[mem_idx] <= mem_wdata; // [RULE4]
    end
end

always @(posedge aclk) begin
    if (!aresetn) begin
        idx_q <= `RAS_IDX_RST; // [RULE4]
        pc_load <= 1'b0;
        pc_load_value <= `RAS_RESET_VECTOR;
        stack_reset_req <= 1'b0;
        // flags survive every reset but power-on
        if (power_on_reset) begin
            full_q <= `RAS_FLAG_RST; // [RULE15]
            unf_q <= `RAS_FLAG_RST;
        end
    end else begin
        idx_q <= idx_d;
        full_q <= full_d;
        unf_q <= unf_d;
        // only the counter itself is loaded, never the latch bytes
        pc_load <= pc_load_d; // [RULE3]
        pc_load_value <= pc_value_d; // [RULE2]
        stack_reset_req <= reset_req_d; // [RULE10] [RULE13]
    end
end

////////////////////////////////////////////////////////////////////////////
// fast shadow stack, not on the register bus

always @(posedge aclk) begin
    if (!aresetn) begin
        sh_status_q <= `RAS_SHADOW_RST;
        sh_working_register_q <= `RAS_SHADOW_RST;
        sh_bsr_q <= `RAS_SHADOW_RST;
        shadow_restore <= 1'b0;
        status_out <= `RAS_SHADOW_RST;
        working_register_out <= `RAS_SHADOW_RST;
        bank_select_register_out <= `RAS_SHADOW_RST;
    end else begin
        shadow_restore <= 1'b0;
        if (irq_ack || (call_push && fast_form)) begin
            sh_status_q <= status_in; // [RULE18] [RULE20] [RULE21]
            sh_working_register_q <= working_register_in;
            sh_bsr_q <= bank_select_register_in;
        end else if (ret_pop && fast_form) begin
            shadow_restore <= 1'b1; // [RULE19]
            status_out <= sh_status_q;
            working_register_out <= sh_working_register_q;
            bank_select_register_out <= sh_bsr_q;
        end
    end
end

endmodule

// ---- verification/ras_monitor.sv ----
// assertion checker for the return stack ports
`timescale 1ns/1ps
module ras_monitor (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // sequencer side
    input wire stack_error_reset_enable,
    input wire call_push,
    input wire irq_ack,
    input wire push_op,
    input wire ret_pop,
    input wire fast_form,
    input wire pc_load,
    input wire [20:0] pc_load_value,
    input wire shadow_restore,
    input wire stack_reset_req,
    input wire stack_full_flag,
    input wire stack_underflow_flag,
    input wire [4:0] stack_depth_index,
    // bus
    input wire s_axi_bvalid
);
    wire psh = call_push | irq_ack | push_op;
    wire en = stack_error_reset_enable;
    wire [4:0] ix = stack_depth_index;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////
    property p_push;
        psh && !(en && ix == 5'h1E) && ix != 5'h1F
            |=> ix == $past(ix) + 5'h01;
    endproperty
    a_push: assert property (p_push) else $error("push index");
    property p_pop;
        ret_pop && !psh && ix != 5'h00 |=> pc_load && ix == $past(ix) - 5'h01;
    endproperty
    a_pop: assert property (p_pop) else $error("pop index");
    property p_under;
        ret_pop && !psh && ix == 5'h00 |=> pc_load && ix == 5'h00
            && pc_load_value == 21'h000000 && stack_underflow_flag;
    endproperty
    a_under: assert property (p_under) else $error("underflow");
    property p_full_off;
        psh && !en && ix >= 5'h1E
            |=> stack_full_flag && ix == 5'h1F && !stack_reset_req;
    endproperty
    a_full_off: assert property (p_full_off) else $error("full");
    property p_full_on;
        psh && en && ix >= 5'h1E
            |=> stack_full_flag && stack_reset_req && ix == 5'h00;
    endproperty
    a_full_on: assert property (p_full_on) else $error("full rst");
    property p_req;
        $rose(stack_reset_req) |-> $past(en);
    endproperty
    a_req: assert property (p_req) else $error("reset req");
    property p_keep;
        $fell(stack_full_flag) || $fell(stack_underflow_flag)
            |-> $rose(s_axi_bvalid);
    endproperty
    a_keep: assert property (p_keep) else $error("flag kept");
    property p_restore;
        ret_pop && fast_form && !psh |=> shadow_restore;
    endproperty
    a_restore: assert property (p_restore) else $error("restore");
    property p_pcload;
        pc_load |-> $past(ret_pop) && !$past(psh);
    endproperty
    a_pcload: assert property (p_pcload) else $error("pc load");
endmodule

// ---- verification/ras_seq_model.sv ----
// sequencer model issuing push, pop and shadow requests
`timescale 1ns/1ps
module ras_seq_model (
    // clock
    input wire aclk,
    // requests
    output reg call_push,
    output reg irq_ack,
    output reg push_op,
    output reg ret_pop,
    output reg pop_op,
    output reg fast_form,
    output reg [20:0] pc_in,
    output reg [7:0] status_in,
    output reg [7:0] working_register_in,
    output reg [7:0] bank_select_register_in
);
    initial begin
        {call_push, irq_ack, push_op, ret_pop, pop_op, fast_form} = 6'h00;
        pc_in = 21'h000000;
        status_in = 8'h00;
        working_register_in = 8'h00;
        bank_select_register_in = 8'h00;
    end
    // kind 0 call, 1 interrupt, 2 push, 3 return, 4 pop
    task automatic req(input int k, input logic f, input logic [20:0] pc,
                       input logic [7:0] v);
        @(posedge aclk);
        call_push <= (k == 0);
        irq_ack <= (k == 1);
        push_op <= (k == 2);
        ret_pop <= (k == 3);
        pop_op <= (k == 4);
        fast_form <= f;
        pc_in <= pc;
        status_in <= v;
        working_register_in <= ~v;
        bank_select_register_in <= v ^ 8'h5A;
        @(posedge aclk);
        {call_push, irq_ack, push_op, ret_pop, pop_op, fast_form} <= 6'h00;
        pc_in <= pc + 21'h000002;
        @(negedge aclk);
    endtask
endmodule

// ---- verification/tb_top.sv ----
// self-checking bench for the return address stack
`timescale 1ns/1ps
module tb_top;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic power_on_reset = 1'h1;
    logic stack_error_reset_enable = 1'h0;
    logic [3:0] s_axi_awaddr = 4'h0;
    logic [2:0] s_axi_awprot = 3'h0;
    logic s_axi_awvalid = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0;
    logic [3:0] s_axi_araddr = 4'h0;
    logic [2:0] s_axi_arprot = 3'h0;
    logic s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0;
    wire call_push, irq_ack, push_op, ret_pop, pop_op, fast_form;
    wire [20:0] pc_in, pc_load_value;
    wire [7:0] status_in, working_register_in, bank_select_register_in;
    wire [7:0] status_out, working_register_out, bank_select_register_out;
    wire pc_load, shadow_restore, stack_reset_req;
    wire stack_full_flag, stack_underflow_flag;
    wire [4:0] stack_depth_index;
    wire s_axi_awready, s_axi_wready, s_axi_arready;
    wire s_axi_bvalid, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;
    logic [31:0] d;
    logic [1:0] r;
    ras_stack DUT (.*);
    ras_seq_model sq (.*);
    always #12.5 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            give_verdict();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            $display("MISMATCH %s exp %h got %h", n, e, g);
            bad_count++;
        end
    endtask
    task automatic rst(input logic p);
        @(posedge aclk);
        power_on_reset <= p;
        aresetn <= 1'h0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        logic aw, w, b;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        b = 1'h0;
        while (!b) begin
            @(negedge aclk);
            aw = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
        end
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a);
        logic ar, b;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        b = 1'h0;
        while (!b) begin
            @(negedge aclk);
            ar = s_axi_arvalid & s_axi_arready;
            b = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'h0;
        end
        s_axi_rready <= 1'h0;
    endtask
    task automatic ctl(input logic [7:0] e);
        rd(4'h0);
        chk("control", {24'h0, e}, d);
    endtask
    task automatic top(input logic [20:0] e);
        rd(4'h4);
        chk("top low", {24'h0, e[7:0]}, d);
        rd(4'h8);
        chk("top high", {24'h0, e[15:8]}, d);
        rd(4'hC);
        chk("top upper", {27'h0, e[20:16]}, d);
    endtask
    task automatic t_stack();
        ctl(8'h00);
        sq.req(0, 1'h0, 21'h012344, 8'h00);
        sq.req(1, 1'h0, 21'h0ABCD6, 8'h00);
        sq.req(2, 1'h0, 21'h1F5432, 8'h00);
        ctl(8'h03);
        top(21'h1F5432);
        sq.req(4, 1'h0, 21'h000010, 8'h00);
        top(21'h0ABCD6);
        sq.req(3, 1'h0, 21'h000010, 8'h00);
        chk("pc", 32'h0ABCD6, pc_load_value);
        sq.req(3, 1'h0, 21'h000010, 8'h00);
        chk("pc", 32'h012344, pc_load_value);
        sq.req(3, 1'h0, 21'h000010, 8'h00);
        chk("pc", 32'h0, pc_load_value);
        ctl(8'h40);
        wr(4'h0, 32'hC0);
        ctl(8'h40);
        wr(4'h0, 32'h00);
        ctl(8'h00);
        $display("stack test done");
    endtask
    task automatic t_soft();
        // no sequencer requests while the top entry is edited
        wr(4'h0, 32'h05);
        chk("wr resp", 32'h0, {30'h0, r});
        ctl(8'h05);
        wr(4'h4, 32'h3C);
        wr(4'h8, 32'h5A);
        wr(4'hC, 32'h17);
        top(21'h175A3C);
        rd(4'h2);
        chk("bad resp", 32'h2, {30'h0, r});
        chk("bad data", 32'h0, d);
        wr(4'h2, 32'h1F);
        chk("wr bad resp", 32'h2, {30'h0, r});
        s_axi_wstrb <= 4'h0;
        wr(4'h0, 32'h1F);
        s_axi_wstrb <= 4'hF;
        ctl(8'h05);
        $display("software test done");
    endtask
    task automatic t_full();
        wr(4'h0, 32'h00);
        for (int i = 0; i < 31; i++)
            sq.req(0, 1'h0, 21'(i * 2), 8'h00);
        ctl(8'h9F);
        sq.req(2, 1'h0, 21'h1FFFFE, 8'h00);
        ctl(8'h9F);
        top(21'h00003C);
        stack_error_reset_enable <= 1'h1;
        wr(4'h0, 32'h1E);
        sq.req(0, 1'h0, 21'h000100, 8'h00);
        chk("reset req", 32'h1, stack_reset_req);
        ctl(8'h80);
        rst(1'h0);
        ctl(8'h80);
        wr(4'h0, 32'h9F);
        ctl(8'h9F);
        top(21'h000102);
        rst(1'h1);
        ctl(8'h00);
        stack_error_reset_enable <= 1'h0;
        $display("full test done");
    endtask
    task automatic t_shadow();
        sq.req(1, 1'h0, 21'h000200, 8'h11);
        sq.req(1, 1'h0, 21'h000300, 8'h22);
        sq.req(3, 1'h1, 21'h000400, 8'h99);
        chk("restore", 32'h1, shadow_restore);
        chk("status", 32'h22, status_out);
        chk("work", 32'hDD, working_register_out);
        chk("bank", 32'h78, bank_select_register_out);
        sq.req(0, 1'h1, 21'h000500, 8'h33);
        sq.req(3, 1'h1, 21'h000600, 8'h99);
        chk("status", 32'h33, status_out);
        $display("shadow test done");
    endtask
    initial begin
        rst(1'h1);
        t_stack();
        t_soft();
        t_full();
        t_shadow();
        give_verdict();
    end
endmodule
bind ras_stack ras_monitor mon (.*);
